/* rtl/rtc_event_pkg.sv */
package rtc_event_pkg;
  // register offsets
  localparam logic [3:0] event_flags_addr = 4'h0;
  localparam logic [3:0] alarm_date_addr = 4'h5;
  localparam logic [3:0] alarm_hours_addr = 4'h4;
  localparam logic [3:0] alarm_minutes_addr = 4'h3;
  localparam logic [3:0] alarm_seconds_addr = 4'h2;
  localparam logic [3:0] irq_config_addr = 4'h6;
  localparam logic [3:0] watchdog_control_addr = 4'h7;
  // event_flags fields
  localparam int watchdog_flag_bit = 7;
  localparam int alarm_flag_bit = 6;
  localparam int power_fail_flag_bit = 5;
  localparam int oscillator_fail_flag_bit = 4;
  localparam int cal_bit = 2;
  localparam int write_lock_bit = 1;
  localparam int read_hold_bit = 0;
  // irq_config fields
  localparam int watchdog_irq_enable_bit = 7;
  localparam int alarm_irq_enable_bit = 6;
  localparam int power_fail_irq_enable_bit = 5;
  localparam int high_active_bit = 3;
  localparam int pulse_mode_bit = 2;
  // watchdog_control fields
  localparam int watchdog_strobe_bit = 7;
  localparam int watchdog_value_unlock_bit = 6;
  localparam int timeout_width = 6;
  // alarm match mask bit
  localparam int match_mask_bit = 7;
  // reset values
  localparam logic [7:0] irq_config_reset = 8'h08;
  localparam logic [7:0] alarm_reset = 8'h80;
  localparam logic [5:0] timeout_reset = 6'h00;
  // timing
  localparam longint clock_hz = 200000000;
  localparam longint pulse_time_ms = 200;
  localparam longint pulse_cycles = (clock_hz * pulse_time_ms) / 1000;
  localparam longint tick_hz = 32;
  localparam longint tick_cycles = clock_hz / tick_hz;
endpackage

/* rtl/wdog_if.sv */
`timescale 1ns/1ps
interface wdog_if;
  logic tick;
  logic reload;
  logic [5:0] timeout;
  logic expire;
  modport ctl (output tick, output reload, output timeout, input expire);
  modport cnt (input tick, input reload, input timeout, output expire);
endinterface

/* rtl/wdog_counter.sv */
`timescale 1ns/1ps
module wdog_counter
  import rtc_event_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // control
  wdog_if.cnt wd
);
  logic [5:0] count;
  logic running;
  wire zero_timeout = (wd.timeout == 6'h00);
  wire at_end = running && (count == 6'h01) && wd.tick;

  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= 6'h00;
      running <= 1'b0;
      wd.expire <= 1'b0;
    end else begin
      wd.expire <= 1'b0;
      if (wd.reload) begin
        count <= wd.timeout;
        running <= !zero_timeout;
      end else if (at_end) begin
        count <= 6'h00;
        running <= 1'b0;
        wd.expire <= 1'b1;
      end else if (running && wd.tick) begin
        count <= count - 6'h01;
      end
    end
  end
endmodule

/* rtl/rtc_event_block.sv */
`timescale 1ns/1ps
module rtc_event_block
  import rtc_event_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register access
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_blocked,
  // current time, bcd
  input wire logic [7:0] time_date,
  input wire logic [7:0] time_hours,
  input wire logic [7:0] time_minutes,
  input wire logic [7:0] time_seconds,
  input wire logic time_update,
  // oscillator
  input wire logic osc_running,
  input wire logic osc_fail,
  // power monitor
  input wire logic supply_low,
  input wire logic restore_done,
  output logic store_start,
  output logic backup_select,
  // interrupt pin
  output logic int_out,
  output logic int_oe
);
  // synchronisers for pin-side levels
  logic [1:0] supply_sync;
  logic [1:0] osc_sync;
  logic [1:0] restore_sync;
  logic [1:0] oscillator_fail_flag_sync;
  always_ff @(posedge mclk) begin
    if (reset) begin
      supply_sync <= 2'b00;
      osc_sync <= 2'b00;
      restore_sync <= 2'b00;
      oscillator_fail_flag_sync <= 2'b00;
    end else begin
      supply_sync <= {supply_sync[0], supply_low};
      osc_sync <= {osc_sync[0], osc_running};
      restore_sync <= {restore_sync[0], restore_done};
      oscillator_fail_flag_sync <= {oscillator_fail_flag_sync[0], osc_fail};
    end
  end
  wire low_s = supply_sync[1];
  wire osc_s = osc_sync[1];
  wire restored_s = restore_sync[1];

  // power state
  typedef enum logic [2:0] {
    pwr_normal_type_s = 3'b001,
    pwr_backup_type_s = 3'b010,
    pwr_restore_type_s = 3'b100
  } pwr_state_type;
  pwr_state_type pwr_state;
  pwr_state_type next_pwr_state;
  always_comb begin
    next_pwr_state = pwr_state;
    unique case (pwr_state)
      pwr_normal_type_s: begin
        if (low_s) next_pwr_state = pwr_backup_type_s;
      end
      pwr_backup_type_s: begin
        if (!low_s) next_pwr_state = pwr_restore_type_s;
      end
      pwr_restore_type_s: begin
        if (low_s) next_pwr_state = pwr_backup_type_s;
        else if (restored_s) next_pwr_state = pwr_normal_type_s;
      end
      default: next_pwr_state = pwr_restore_type_s;
    endcase
  end
  wire on_normal = (pwr_state == pwr_normal_type_s);
  wire enter_backup = on_normal && low_s;

  // registers
  logic [7:0] flags;
  logic [7:0] irq_config;
  logic [5:0] timeout;
  logic wdog_unlock;
  logic [7:0] alarm_stage [4];
  logic [7:0] alarm_live [4];
  logic [7:0] time_now [4];
  assign time_now[0] = time_seconds;
  assign time_now[1] = time_minutes;
  assign time_now[2] = time_hours;
  assign time_now[3] = time_date;

  wire access_ok = on_normal;
  wire wr_ok = reg_write && access_ok;
  wire rd_flags = reg_read && access_ok && (reg_addr == event_flags_addr);
  wire lock = flags[write_lock_bit];
  wire wr_flags = wr_ok && (reg_addr == event_flags_addr);
  wire wr_irq = wr_ok && lock && (reg_addr == irq_config_addr);
  wire wr_wdog = wr_ok && lock && (reg_addr == watchdog_control_addr);
  wire lock_falls = wr_flags && lock && !reg_wdata[write_lock_bit];
  wire strobe = wr_wdog && reg_wdata[watchdog_strobe_bit];

  // 32 Hz tick divider, held while oscillator is stopped
  logic [22:0] div_count;
  logic tick;
  always_ff @(posedge mclk) begin
    if (reset) begin
      div_count <= 23'h000000;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (osc_s) begin
        if (div_count == 23'(tick_cycles - 1)) begin
          div_count <= 23'h000000;
          tick <= 1'b1;
        end else begin
          div_count <= div_count + 23'h000001;
        end
      end
    end
  end

  // power-up load pulse for the watchdog
  logic powerup_done;
  always_ff @(posedge mclk) begin
    if (reset) powerup_done <= 1'b0;
    else powerup_done <= 1'b1;
  end

  wdog_if wd ();
  assign wd.tick = tick;
  assign wd.reload = !powerup_done || strobe;
  assign wd.timeout = timeout;
  wdog_counter u_wdog (
    .mclk(mclk),
    .reset(reset),
    .wd(wd)
  );

  // alarm match
  logic [3:0] field_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_field
      assign field_hit[gi] = alarm_live[gi][match_mask_bit] ||
        (alarm_live[gi][6:0] == time_now[gi][6:0]);
    end
  endgenerate
  wire [3:0] masks = {alarm_live[3][7], alarm_live[2][7], alarm_live[1][7], alarm_live[0][7]};
  wire alarm_enabled = (masks != 4'hF);
  wire alarm_event = time_update && alarm_enabled && (&field_hit);

  // alarm registers: staged while locked, applied when lock clears
  generate
    for (gi = 0; gi < 4; gi++) begin : g_alarm
      wire [3:0] my_addr = alarm_seconds_addr + 4'(gi);
      always_ff @(posedge mclk) begin
        if (reset) begin
          alarm_stage[gi] <= alarm_reset;
          alarm_live[gi] <= alarm_reset;
        end else begin
          if (wr_ok && lock && reg_addr == my_addr) alarm_stage[gi] <= reg_wdata;
          if (lock_falls) alarm_live[gi] <= alarm_stage[gi];
        end
      end
    end
  endgenerate

  // flags register
  wire wdog_event = wd.expire;
  wire pf_event = enter_backup;
  logic [7:0] next_flags;
  always_comb begin
    next_flags = flags;
    if (rd_flags) begin
      next_flags[watchdog_flag_bit] = 1'b0;
      next_flags[alarm_flag_bit] = 1'b0;
      next_flags[power_fail_flag_bit] = 1'b0;
    end
    if (wr_flags) begin
      next_flags[write_lock_bit] = reg_wdata[write_lock_bit];
      next_flags[read_hold_bit] = reg_wdata[read_hold_bit];
      if (lock) begin
        next_flags[cal_bit] = reg_wdata[cal_bit];
        if (!reg_wdata[oscillator_fail_flag_bit]) next_flags[oscillator_fail_flag_bit] = 1'b0;
      end
    end
    if (wdog_event) next_flags[watchdog_flag_bit] = 1'b1;
    if (alarm_event) next_flags[alarm_flag_bit] = 1'b1;
    if (pf_event) next_flags[power_fail_flag_bit] = 1'b1;
    if (oscillator_fail_flag_sync[1]) next_flags[oscillator_fail_flag_bit] = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      flags <= 8'h00;
      irq_config <= irq_config_reset;
      timeout <= timeout_reset;
      wdog_unlock <= 1'b0;
      pwr_state <= pwr_normal_type_s;
    end else begin
      flags <= next_flags;
      pwr_state <= next_pwr_state;
      if (wr_irq) irq_config <= reg_wdata & 8'hEC;
      if (wr_wdog) begin
        wdog_unlock <= reg_wdata[watchdog_value_unlock_bit];
        if (!reg_wdata[watchdog_value_unlock_bit] && !wdog_unlock)
          timeout <= reg_wdata[5:0];
      end
    end
  end

  // interrupt generation
  wire wdog_new = wdog_event && irq_config[watchdog_irq_enable_bit];
  wire alarm_new = alarm_event && irq_config[alarm_irq_enable_bit];
  wire pf_new = pf_event && irq_config[power_fail_irq_enable_bit];
  wire irq_source = (flags[watchdog_flag_bit] && irq_config[watchdog_irq_enable_bit]) ||
    (flags[alarm_flag_bit] && irq_config[alarm_irq_enable_bit]) ||
    (flags[power_fail_flag_bit] && irq_config[power_fail_irq_enable_bit]);
  wire fire_event = wdog_new || alarm_new || pf_new;
  wire pulse_mode = irq_config[pulse_mode_bit];
  logic [25:0] pulse_count;
  logic pulse_on;
  always_ff @(posedge mclk) begin
    if (reset) begin
      pulse_count <= 26'h0000000;
      pulse_on <= 1'b0;
    end else if (!on_normal || rd_flags) begin
      pulse_on <= 1'b0;
      pulse_count <= 26'h0000000;
    end else if (fire_event && pulse_mode) begin
      pulse_on <= 1'b1;
      pulse_count <= 26'(pulse_cycles - 1);
    end else if (pulse_on) begin
      if (pulse_count == 26'h0000000) pulse_on <= 1'b0;
      else pulse_count <= pulse_count - 26'h0000001;
    end
  end
  // level mode: active while an enabled flag stands; the read clears it
  wire level_active = !pulse_mode && irq_source && !rd_flags;
  wire int_active = on_normal && (pulse_mode ? pulse_on : level_active);
  wire high_mode = irq_config[high_active_bit];

  // read data
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      event_flags_addr: rd_mux = flags;
      irq_config_addr: rd_mux = irq_config;
      watchdog_control_addr: rd_mux = {1'b0, wdog_unlock, timeout};
      alarm_seconds_addr: rd_mux = alarm_stage[0];
      alarm_minutes_addr: rd_mux = alarm_stage[1];
      alarm_hours_addr: rd_mux = alarm_stage[2];
      alarm_date_addr: rd_mux = alarm_stage[3];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_blocked <= 1'b0;
      store_start <= 1'b0;
      backup_select <= 1'b0;
      int_out <= 1'b0;
      int_oe <= 1'b0;
    end else begin
      if (reg_read && access_ok) reg_rdata <= rd_mux;
      reg_blocked <= !access_ok;
      store_start <= enter_backup;
      backup_select <= (next_pwr_state != pwr_normal_type_s);
      if (high_mode) begin
        int_out <= int_active;
        int_oe <= on_normal;
      end else begin
        int_out <= 1'b0;
        int_oe <= int_active;
      end
    end
  end
endmodule

/* dv/rtc_event_checker.sv */
`timescale 1ns/1ps
module rtc_event_checker
  import rtc_event_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register access
  input wire logic reg_read,
  input wire logic [3:0] reg_addr,
  input wire logic reg_blocked,
  // power monitor
  input wire logic supply_low,
  input wire logic restore_done,
  input wire logic store_start,
  input wire logic backup_select,
  // interrupt pin
  input wire logic int_out,
  input wire logic int_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_fall;
    $rose(supply_low);
  endsequence
  sequence s_back;
    ##[1:6] (backup_select && reg_blocked);
  endsequence
  sequence s_ret;
    $rose(restore_done) && !supply_low;
  endsequence
  a_enter_backup: assert property (s_fall |-> s_back)
    else $error("backup not entered after supply drop");
  a_store_started: assert property (s_fall |-> ##[1:6] store_start)
    else $error("store not started after supply drop");
  a_store_pulse: assert property (store_start |=> !store_start)
    else $error("store start longer than one cycle");
  a_stay_backup: assert property (backup_select && !restore_done |=> backup_select)
    else $error("backup left before restore finished");
  a_leave_backup: assert property (s_ret |-> ##[1:6] (!backup_select && !reg_blocked))
    else $error("access not restored after restore delay");
  a_no_irq_backup: assert property (backup_select && $past(backup_select) |-> !int_out)
    else $error("interrupt driven on backup power");
  a_read_clears: assert property (reg_read && reg_addr == event_flags_addr && !reg_blocked
    |-> ##2 !int_out)
    else $error("interrupt not released after flags read");
  a_oe_drive: assert property (int_out |-> int_oe)
    else $error("interrupt high without drive enable");
endmodule

bind rtc_event_block rtc_event_checker u_rtc_event_checker (.mclk, .reset, .reg_read,
  .reg_addr, .reg_blocked, .supply_low, .restore_done, .store_start, .backup_select,
  .int_out, .int_oe);

/* dv/rtc_host_model.sv */
`timescale 1ns/1ps
module rtc_host_model (
  // clock
  input wire logic mclk,
  // register access
  output logic reg_write,
  output logic reg_read,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // interrupt pin
  input wire logic int_out,
  input wire logic int_oe,
  output logic int_pin
);
  // pull-up holds the line high when nothing drives it
  assign int_pin = int_oe ? int_out : 1'b1;
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    @(posedge mclk);
    #1 d = reg_rdata;
  endtask
endmodule

/* dv/test_rtc_event_block.sv */
`timescale 1ns/1ps
module test_rtc_event_block
  import rtc_event_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic reg_write, reg_read, reg_blocked, time_update, osc_running, osc_fail;
  logic supply_low, restore_done, store_start, backup_select, int_out, int_oe, int_pin;
  logic store_seen = 1'b0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [31:0] tm;
  logic [7:0] wd_in [6] = '{8'h05, 8'h45, 8'h4A, 8'hC0, 8'h00, 8'h00};
  logic [7:0] wd_exp [6] = '{8'h05, 8'h45, 8'h45, 8'h45, 8'h05, 8'h00};
  // last alarm values per field, so a new case never matches the stale live alarm
  logic [7:0] pv [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  // cfg, masks, mismatches; seconds mask kept clear except in the disabled case
  logic [15:0] ac [10] = '{16'h4800, 16'h4000, 16'h4C00, 16'h4400, 16'h0800,
    16'h4801, 16'h4888, 16'h4866, 16'h48E1, 16'h48F0};
  int errors = 0;
  int comparisons = 0;
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) if (store_start === 1'b1) store_seen <= 1'b1;
  rtc_event_block u_rtc_event_block (.mclk, .reset, .reg_write, .reg_read, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_blocked, .time_date(tm[31:24]), .time_hours(tm[23:16]),
    .time_minutes(tm[15:8]), .time_seconds(tm[7:0]), .time_update, .osc_running,
    .osc_fail, .supply_low, .restore_done, .store_start, .backup_select, .int_out, .int_oe);
  rtc_host_model u_rtc_host_model (.mclk, .reg_write, .reg_read, .reg_addr, .reg_wdata,
    .reg_rdata, .int_out, .int_oe, .int_pin);
  function automatic logic exp_fire(input logic [3:0] m, input logic [3:0] mm);
    return m != 4'hF && (mm & ~m) == 4'h0;
  endfunction
  function automatic logic [1:0] exp_pin(input logic [7:0] c, input logic act);
    return act ? {1'b1, c[high_active_bit]} : {c[high_active_bit], ~c[high_active_bit]};
  endfunction
  task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_pin(input logic [1:0] exp);
    check_data({6'h00, int_oe, int_pin}, {6'h00, exp});
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    u_rtc_host_model.rd(a, d);
    check_data(d & m, exp);
  endtask
  task automatic complete_run();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic give_up();
    errors++;
    $display("timeout at %0t", $time);
    complete_run();
  endtask
  task automatic wait_blocked(input logic v);
    int k;
    for (k = 0; k < 32 && (reg_blocked !== v || backup_select !== v); k++) @(negedge mclk);
    if (k == 32) give_up();
  endtask
  task automatic pulse_time();
    @(posedge mclk);
    time_update <= 1'b1;
    @(posedge mclk);
    time_update <= 1'b0;
  endtask
  task automatic alarm_case(input logic [7:0] c, input logic [3:0] m, input logic [3:0] mm);
    logic [7:0] v;
    logic act;
    int k;
    act = exp_fire(m, mm) && c[alarm_irq_enable_bit];
    u_rtc_host_model.wr(event_flags_addr, 8'h02);
    u_rtc_host_model.wr(irq_config_addr, c);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom) & 8'h7F;
      if (v[6:1] == pv[i][6:1]) v = v ^ 8'h02;
      pv[i] = v;
      u_rtc_host_model.wr(alarm_seconds_addr + 4'(i), v | {m[i], 7'h00});
      tm[8*i +: 8] <= v ^ {7'h00, mm[i]};
    end
    pulse_time();
    rd_chk(event_flags_addr, 8'hFF, 8'h02);
    u_rtc_host_model.wr(event_flags_addr, 8'h00);
    pulse_time();
    for (k = 0; k < 20 && act && {int_oe, int_pin} !== exp_pin(c, 1'b1); k++) @(negedge mclk);
    if (k == 20) give_up();
    repeat (32) @(negedge mclk);
    check_pin(exp_pin(c, act));
    rd_chk(event_flags_addr, 8'hFF, {1'b0, exp_fire(m, mm), 6'h00});
    repeat (2) @(negedge mclk);
    check_pin(exp_pin(c, 1'b0));
    rd_chk(event_flags_addr, 8'hFF, 8'h00);
  endtask
  initial begin
    tm = 32'h7F7F7F7F;
    time_update = 1'b0;
    osc_running = 1'b1;
    osc_fail = 1'b0;
    supply_low = 1'b0;
    restore_done = 1'b1;
    void'($urandom(32'hc4ce));
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (16) @(posedge mclk);
    for (int i = 2; i < 6; i++) rd_chk(4'(i), 8'hFF, alarm_reset);
    rd_chk(irq_config_addr, 8'hEC, irq_config_reset);
    rd_chk(watchdog_control_addr, 8'hFF, 8'h00);
    rd_chk(event_flags_addr, 8'hFF, 8'h00);
    u_rtc_host_model.wr(irq_config_addr, 8'hE4);
    u_rtc_host_model.wr(alarm_seconds_addr, 8'h11);
    rd_chk(irq_config_addr, 8'hEC, irq_config_reset);
    rd_chk(alarm_seconds_addr, 8'hFF, alarm_reset);
    $display("test reset and lock done");
    u_rtc_host_model.wr(event_flags_addr, 8'h02);
    foreach (wd_in[i]) begin
      u_rtc_host_model.wr(watchdog_control_addr, wd_in[i]);
      rd_chk(watchdog_control_addr, 8'hFF, wd_exp[i]);
    end
    $display("test watchdog register done");
    foreach (ac[i]) begin
      alarm_case(ac[i][15:8], ac[i][7:4], ac[i][3:0]);
      $display("test alarm %0d done", i);
    end
    u_rtc_host_model.wr(event_flags_addr, 8'h02);
    u_rtc_host_model.wr(irq_config_addr, 8'h28);
    u_rtc_host_model.wr(event_flags_addr, 8'h00);
    @(posedge mclk);
    supply_low <= 1'b1;
    restore_done <= 1'b0;
    wait_blocked(1'b1);
    check_data({7'h00, store_seen}, 8'h01);
    check_data({7'h00, int_out}, 8'h00);
    rd_chk(irq_config_addr, 8'hFF, 8'h00);
    @(posedge mclk);
    supply_low <= 1'b0;
    repeat (20) @(negedge mclk);
    check_data({7'h00, reg_blocked}, 8'h01);
    @(posedge mclk);
    restore_done <= 1'b1;
    wait_blocked(1'b0);
    rd_chk(event_flags_addr, 8'hFF, 8'h20);
    $display("test power fail done");
    complete_run();
  end
endmodule
